// *** cpm_pkg.sv ***
// shared constants and types for the configuration port and mode control
package cpm_pkg;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int ADDR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
  localparam int RW_BIT = 15;
  localparam int RSV_HI = 14;
  localparam int RSV_LO = 12;
  localparam int REG_ADDR_W = 12;
  localparam logic [2:0] RSV_ZERO = 3'h0;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h10;
  localparam logic [4:0] CNT_LAST_BIT = 5'h17;
  localparam logic [4:0] CNT_FRAME_END = 5'h18;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_POWER_CONTROL = 12'h101;
  localparam logic [11:0] OFS_PIN_FUNCTION_SELECT = 12'h146;
  localparam logic [11:0] OFS_OUTPUT_FORMAT_CONTROL = 12'h162;
  localparam logic [11:0] OFS_BAND_SOURCE_SELECT = 12'h163;
  localparam logic [11:0] OFS_LATENCY_PATH_CONTROL = 12'h165;
  localparam logic [11:0] OFS_BAND_COUNT_DECIMATION = 12'h169;

  // ----------------------------------------------------------------
  // reset values and the unmapped read value
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_PIN_FUNCTION_SELECT = 8'h00;
  localparam logic [7:0] RST_OUTPUT_FORMAT_CONTROL = 8'h00;
  localparam logic [7:0] RST_BAND_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_LATENCY_PATH_CONTROL = 8'h00;
  localparam logic [7:0] RST_BAND_COUNT_DECIMATION = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions and codes
  // ----------------------------------------------------------------
  localparam int PWR_DOWN_BIT = 4;
  localparam int LOW_LATENCY_BIT = 4;
  localparam int PIN_FN_HI = 4;
  localparam int PIN_FN_LO = 0;
  localparam logic [4:0] PIN_FN_PDN_ON_PIN1 = 5'h03;
  localparam logic [4:0] PIN_FN_PDN_ON_PIN0_A = 5'h0a;
  localparam logic [4:0] PIN_FN_PDN_ON_PIN0_B = 5'h0b;
  localparam logic [4:0] PIN_FN_DEFAULT = 5'h00;
  localparam int BAND0_SRC_HI = 1;
  localparam int BAND0_SRC_LO = 0;
  localparam int DECIM_HI = 3;
  localparam int DECIM_LO = 0;
  localparam logic [3:0] DECIM_BYPASS = 4'h0;

  typedef enum logic [1:0] {
    SRC_CHAN_A = 2'h0,
    SRC_CHAN_B = 2'h1,
    SRC_AVERAGE = 2'h2,
    SRC_SPARE = 2'h3
  } cpm_band_src_e;

  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int LOW_LAT_CYCLES = 9;
  localparam int NORMAL_LAT_CYCLES = 12;

  typedef struct packed {
    logic [SAMPLE_W-1:0] chanA;
    logic [SAMPLE_W-1:0] chanB;
  } cpm_sample_pair_s;

  typedef struct packed {
    logic lowLatency;
    cpm_band_src_e band0Source;
    logic decimBypass;
  } cpm_path_cfg_s;

endpackage

// *** cpm_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module cpm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      syncOut <= '0;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end

endmodule

// *** cpm_sample_path.sv ***
// sample routing: low latency bypass, channel averaging, band source mux
`timescale 1ns/1ns
module cpm_sample_path (
  input wire logic clk,
  input wire logic rst,
  input cpm_pkg::cpm_path_cfg_s cfg,
  input cpm_pkg::cpm_sample_pair_s sampleIn,
  output cpm_pkg::cpm_sample_pair_s sampleOut,
  output logic [cpm_pkg::SAMPLE_W-1:0] decimFeed,
  output logic decimFeedValid
);

  localparam int LLD = cpm_pkg::LOW_LAT_CYCLES - 1;
  localparam int NLD = cpm_pkg::NORMAL_LAT_CYCLES - 1;

  cpm_pkg::cpm_sample_pair_s llPipe [LLD];
  cpm_pkg::cpm_sample_pair_s normPipe [NLD];
  cpm_pkg::cpm_sample_pair_s routed;
  logic [cpm_pkg::SAMPLE_W:0] pairSum;
  logic [cpm_pkg::SAMPLE_W-1:0] average;
  logic [cpm_pkg::SAMPLE_W-1:0] band0Sample;

  // ----------------------------------------------------------------
  // averaging of same-cycle samples
  // ----------------------------------------------------------------
  // sign extension keeps the sum from overflowing for negative codes; the halving rounds toward minus infinity
  assign pairSum = {sampleIn.chanA[cpm_pkg::SAMPLE_W-1], sampleIn.chanA}
                 + {sampleIn.chanB[cpm_pkg::SAMPLE_W-1], sampleIn.chanB};
  assign average = pairSum[cpm_pkg::SAMPLE_W:1];

  always_comb begin
    case (cfg.band0Source)
      cpm_pkg::SRC_CHAN_A: band0Sample = sampleIn.chanA;
      cpm_pkg::SRC_CHAN_B: band0Sample = sampleIn.chanB;
      cpm_pkg::SRC_AVERAGE: band0Sample = average;
      default: band0Sample = sampleIn.chanA;
    endcase
  end

  always_comb begin
    routed = sampleIn;
    if (cfg.decimBypass) begin
      routed.chanA = band0Sample;
    end
  end

  // ----------------------------------------------------------------
  // delay lines; output register is the final stage of each
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      llPipe[0] <= '0;
      normPipe[0] <= '0;
    end else begin
      llPipe[0] <= sampleIn;
      normPipe[0] <= routed;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < LLD; gi++) begin : gLowLat
      always_ff @(posedge clk) begin
        if (rst) begin
          llPipe[gi] <= '0;
        end else begin
          llPipe[gi] <= llPipe[gi-1];
        end
      end
    end
    for (gi = 1; gi < NLD; gi++) begin : gNormal
      always_ff @(posedge clk) begin
        if (rst) begin
          normPipe[gi] <= '0;
        end else begin
          normPipe[gi] <= normPipe[gi-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      sampleOut <= '0;
    end else if (cfg.lowLatency) begin
      sampleOut <= llPipe[LLD-1];
    end else begin
      sampleOut <= normPipe[NLD-1];
    end
  end

  // averaged or raw band 0 stream into the decimation chain
  always_ff @(posedge clk) begin
    if (rst) begin
      decimFeed <= '0;
      decimFeedValid <= 1'b0;
    end else begin
      decimFeed <= band0Sample;
      decimFeedValid <= !cfg.decimBypass && !cfg.lowLatency;
    end
  end

endmodule

// *** cpm_config_port.sv ***
// serial configuration port, mode registers, pin functions and power down
`timescale 1ns/1ns
module cpm_config_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_select_n,
  input wire logic serialClk,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe,
  input wire logic aux_pin_0,
  input wire logic aux_pin_1,
  input wire logic sampleClkPresent,
  input cpm_pkg::cpm_sample_pair_s sampleIn,
  output cpm_pkg::cpm_sample_pair_s sampleOut,
  output logic [cpm_pkg::SAMPLE_W-1:0] decimFeed,
  output logic decimFeedValid,
  output logic sync_reference,
  output logic globalPowerDown,
  output logic [7:0] outputFormat
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] pinsSync;
  logic selN;
  logic sclkS;
  logic sdiS;
  logic pin0S;
  logic pin1S;
  logic clkPresS;

  cpm_sync #(
    .WIDTH(6)
  ) uSync (
    .clk(clk),
    .rst(rst),
    .asyncIn({sampleClkPresent, aux_pin_1, aux_pin_0, serialDataIn, serialClk, !serial_select_n}),
    .syncOut(pinsSync)
  );

  // select enters inverted so the cleared synchroniser reads as deselected
  // through reset and just after its release
  assign selN = !pinsSync[0];
  assign sclkS = pinsSync[1];
  assign sdiS = pinsSync[2];
  assign pin0S = pinsSync[3];
  assign pin1S = pinsSync[4];
  assign clkPresS = pinsSync[5];

  // ----------------------------------------------------------------
  // serial clock edges
  // ----------------------------------------------------------------
  logic sclkPrev_ff;
  logic sclkRise;
  logic sclkFall;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclkPrev_ff <= 1'b0;
    end else begin
      sclkPrev_ff <= sclkS;
    end
  end

  // edges are seen three clocks late, so each link half period needs three clocks
  assign sclkRise = !selN && sclkS && !sclkPrev_ff;
  assign sclkFall = !selN && !sclkS && sclkPrev_ff;

  // ----------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------
  logic [4:0] bitCnt_ff;
  logic [cpm_pkg::ADDR_BITS-1:0] addrShift_ff;
  logic [cpm_pkg::DATA_BITS-1:0] dataShift_ff;
  logic inAddr;
  logic [cpm_pkg::ADDR_BITS-1:0] nxt_addr;
  logic frameIsRead;
  logic frameAddrOk;
  logic writeStrobe;
  logic [7:0] writeData;
  logic [cpm_pkg::REG_ADDR_W-1:0] regAddr;
  logic frameDone;

  assign inAddr = bitCnt_ff < cpm_pkg::CNT_ADDR_DONE;
  // rising edges past the last data bit are ignored until select goes high
  assign frameDone = bitCnt_ff == cpm_pkg::CNT_FRAME_END;
  assign nxt_addr = {addrShift_ff[cpm_pkg::ADDR_BITS-2:0], sdiS};
  assign frameIsRead = addrShift_ff[cpm_pkg::RW_BIT];
  assign frameAddrOk = addrShift_ff[cpm_pkg::RSV_HI:cpm_pkg::RSV_LO] == cpm_pkg::RSV_ZERO;
  assign regAddr = addrShift_ff[cpm_pkg::REG_ADDR_W-1:0];
  assign writeData = {dataShift_ff[cpm_pkg::DATA_BITS-2:0], sdiS};
  // the last rising edge commits; read frames never reach the store
  assign writeStrobe = sclkRise && bitCnt_ff == cpm_pkg::CNT_LAST_BIT
                    && !frameIsRead && frameAddrOk;

  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt_ff <= '0;
      addrShift_ff <= '0;
      dataShift_ff <= '0;
    end else if (selN) begin
      bitCnt_ff <= '0;
    end else if (sclkRise && !frameDone) begin
      bitCnt_ff <= bitCnt_ff + 5'h01;
      if (inAddr) begin
        addrShift_ff <= nxt_addr;
      end else begin
        dataShift_ff <= writeData;
      end
    end
  end

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  logic [7:0] powerCtrl_ff;
  logic [7:0] pinFunction_ff;
  logic [7:0] outFormat_ff;
  logic [7:0] bandSource_ff;
  logic [7:0] latencyCtrl_ff;
  logic [7:0] bandCount_ff;

  // defaults leave the converter streaming with no serial access
  always_ff @(posedge clk) begin
    if (rst) begin
      powerCtrl_ff <= cpm_pkg::RST_POWER_CONTROL;
      pinFunction_ff <= cpm_pkg::RST_PIN_FUNCTION_SELECT;
      outFormat_ff <= cpm_pkg::RST_OUTPUT_FORMAT_CONTROL;
      bandSource_ff <= cpm_pkg::RST_BAND_SOURCE_SELECT;
      latencyCtrl_ff <= cpm_pkg::RST_LATENCY_PATH_CONTROL;
      bandCount_ff <= cpm_pkg::RST_BAND_COUNT_DECIMATION;
    end else if (writeStrobe) begin
      case (regAddr)
        cpm_pkg::OFS_POWER_CONTROL: powerCtrl_ff <= writeData;
        cpm_pkg::OFS_PIN_FUNCTION_SELECT: pinFunction_ff <= writeData;
        cpm_pkg::OFS_OUTPUT_FORMAT_CONTROL: outFormat_ff <= writeData;
        cpm_pkg::OFS_BAND_SOURCE_SELECT: bandSource_ff <= writeData;
        cpm_pkg::OFS_LATENCY_PATH_CONTROL: latencyCtrl_ff <= writeData;
        cpm_pkg::OFS_BAND_COUNT_DECIMATION: bandCount_ff <= writeData;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [7:0] readValue;
  logic [7:0] readShift_ff;

  always_comb begin
    case (regAddr)
      cpm_pkg::OFS_POWER_CONTROL: readValue = powerCtrl_ff;
      cpm_pkg::OFS_PIN_FUNCTION_SELECT: readValue = pinFunction_ff;
      cpm_pkg::OFS_OUTPUT_FORMAT_CONTROL: readValue = outFormat_ff;
      cpm_pkg::OFS_BAND_SOURCE_SELECT: readValue = bandSource_ff;
      cpm_pkg::OFS_LATENCY_PATH_CONTROL: readValue = latencyCtrl_ff;
      cpm_pkg::OFS_BAND_COUNT_DECIMATION: readValue = bandCount_ff;
      default: readValue = cpm_pkg::READ_UNMAPPED;
    endcase
  end

  logic inReadData;
  logic readLoad;
  logic readAdvance;

  assign inReadData = !inAddr && !frameDone && frameIsRead && frameAddrOk;
  // captured while the clock sits high after the last address bit, once the
  // full address is in; the raised drive enable stops any reload
  assign readLoad = bitCnt_ff == cpm_pkg::CNT_ADDR_DONE && !serialDataOe;
  assign readAdvance = sclkFall && inReadData;

  // snapshot at the end of the address so a late write cannot tear the byte
  always_ff @(posedge clk) begin
    if (rst) begin
      readShift_ff <= '0;
    end else if (readAdvance) begin
      readShift_ff <= {readShift_ff[6:0], 1'b0};
    end else if (readLoad) begin
      readShift_ff <= readValue;
    end
  end

  // ----------------------------------------------------------------
  // read data launch
  // ----------------------------------------------------------------
  // launch on each falling edge of the data phase; the controller
  // captures on the following rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
    end else if (selN || !frameIsRead) begin
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
    end else if (readAdvance) begin
      serialDataOut <= readShift_ff[7];
      serialDataOe <= 1'b1;
    end else if (sclkFall && frameDone) begin
      serialDataOe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin functions and power down
  // ----------------------------------------------------------------
  logic [4:0] pinFn;
  logic pinPdnReq;
  logic pdnReq;

  assign pinFn = pinFunction_ff[cpm_pkg::PIN_FN_HI:cpm_pkg::PIN_FN_LO];

  always_comb begin
    case (pinFn)
      cpm_pkg::PIN_FN_PDN_ON_PIN1: pinPdnReq = pin1S;
      cpm_pkg::PIN_FN_PDN_ON_PIN0_A: pinPdnReq = pin0S;
      cpm_pkg::PIN_FN_PDN_ON_PIN0_B: pinPdnReq = pin0S;
      default: pinPdnReq = 1'b0;
    endcase
  end

  assign pdnReq = powerCtrl_ff[cpm_pkg::PWR_DOWN_BIT] | pinPdnReq;

  // ----------------------------------------------------------------
  // power down and pin outputs
  // ----------------------------------------------------------------
  // without a sample clock the request is held off, state unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      globalPowerDown <= 1'b0;
    end else if (clkPresS) begin
      globalPowerDown <= pdnReq;
    end
  end

  // pin 0 carries the sync reference only in the default assignment
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reference <= 1'b0;
    end else begin
      sync_reference <= (pinFn == cpm_pkg::PIN_FN_DEFAULT) && pin0S;
    end
  end

  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  // registered copy so the format output comes straight from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      outputFormat <= cpm_pkg::RST_OUTPUT_FORMAT_CONTROL;
    end else begin
      outputFormat <= outFormat_ff;
    end
  end

  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  cpm_pkg::cpm_path_cfg_s pathCfg;

  assign pathCfg.lowLatency = latencyCtrl_ff[cpm_pkg::LOW_LATENCY_BIT];
  assign pathCfg.band0Source = cpm_pkg::cpm_band_src_e'(bandSource_ff[cpm_pkg::BAND0_SRC_HI:cpm_pkg::BAND0_SRC_LO]);
  assign pathCfg.decimBypass = bandCount_ff[cpm_pkg::DECIM_HI:cpm_pkg::DECIM_LO] == cpm_pkg::DECIM_BYPASS;

  cpm_sample_path uPath (
    .clk(clk),
    .rst(rst),
    .cfg(pathCfg),
    .sampleIn(sampleIn),
    .sampleOut(sampleOut),
    .decimFeed(decimFeed),
    .decimFeedValid(decimFeedValid)
  );

endmodule

// *** cpm_config_port_checker.sv ***
// timing checks on the serial configuration port and mode outputs
`timescale 1ns/1ns
module cpm_config_port_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_select_n,
  input wire logic serialClk,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic aux_pin_0,
  input wire logic sampleClkPresent,
  input wire logic sync_reference,
  input wire logic globalPowerDown,
  input wire logic [7:0] outputFormat
);
  // ----
  // raw frame tracking
  // ----
  logic sclkPrev_ff;
  logic [4:0] rises_ff;
  logic idle_ff;
  always_ff @(posedge clk) begin
    sclkPrev_ff <= serialClk;
  end
  // counts rising pin edges seen inside the current frame
  always_ff @(posedge clk) begin
    if (rst || serial_select_n) begin
      rises_ff <= 5'h00;
    end else if (serialClk && !sclkPrev_ff) begin
      rises_ff <= rises_ff + 5'h01;
    end
  end
  // no frame yet, so pin function still at its reset choice
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_ff <= 1'b1;
    end else if (!serial_select_n) begin
      idle_ff <= 1'b0;
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_deselected;
    serial_select_n [*5];
  endsequence
  sequence s_oe_start;
    $rose(serialDataOe);
  endsequence
  property p_oe_release;
    s_deselected |-> !serialDataOe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data pin driven while deselected");
  property p_oe_start;
    s_oe_start |-> rises_ff == 5'h10 && !serialClk;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("read drive began at wrong point");
  property p_oe_window;
    serialDataOe && !serial_select_n |-> rises_ff >= 5'h10 && rises_ff <= 5'h18;
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("data pin driven outside data phase");
  property p_oe_end;
    $fell(serialDataOe) && !serial_select_n |-> rises_ff == 5'h18;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("read drive did not span eight bits");
  property p_bit_launch;
    serialDataOe && $past(serialDataOe) && $changed(serialDataOut) |-> !$past(serialClk) && !$past(serialClk, 2);
  endproperty
  a_bit_launch: assert property (p_bit_launch) else $error("read bit changed off a falling edge");
  property p_fmt_commit;
    $changed(outputFormat) |-> rises_ff == 5'h18 && !serial_select_n;
  endproperty
  a_fmt_commit: assert property (p_fmt_commit) else $error("register changed outside a full frame");
  property p_pdn_hold;
    !sampleClkPresent [*4] |-> $stable(globalPowerDown);
  endproperty
  a_pdn_hold: assert property (p_pdn_hold) else $error("power down moved without sample clock");
  property p_sync_default;
    (idle_ff && $stable(aux_pin_0)) [*5] |-> sync_reference == aux_pin_0;
  endproperty
  a_sync_default: assert property (p_sync_default) else $error("pin 0 not passed as sync reference");
endmodule

bind cpm_config_port cpm_config_port_checker i_chk (
  .clk(clk), .rst(rst), .serial_select_n(serial_select_n), .serialClk(serialClk),
  .serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .aux_pin_0(aux_pin_0),
  .sampleClkPresent(sampleClkPresent), .sync_reference(sync_reference),
  .globalPowerDown(globalPowerDown), .outputFormat(outputFormat)
);

// *** cpm_host_model.sv ***
// behavioural controller running frames on the serial configuration link
`timescale 1ns/1ns
module cpm_host_model (
  input wire logic clk,
  input wire logic dataWire,
  output logic serial_select_n,
  output logic serialClk,
  output logic hostData,
  output logic hostOe
);
  initial begin
    serial_select_n = 1'b1;
    serialClk = 1'b0;
    hostData = 1'b0;
    hostOe = 1'b0;
  end
  // ----
  // one frame; clock idles low between frames, half is clk cycles per phase
  // ----
  task automatic frame(input logic [23:0] word, input int nBits, input int half, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(negedge clk);
    serial_select_n = 1'b0;
    repeat (half) @(negedge clk);
    for (i = 0; i < nBits; i++) begin
      // released during the data phase of a read
      hostOe = !(word[23] && i >= 16);
      hostData = word[23 - i];
      repeat (half) @(negedge clk);
      if (i >= 16) begin
        rd = {rd[6:0], dataWire};
      end
      serialClk = 1'b1;
      repeat (half) @(negedge clk);
      serialClk = 1'b0;
    end
    repeat (half) @(negedge clk);
    serial_select_n = 1'b1;
    hostOe = 1'b0;
    repeat (half) @(negedge clk);
  endtask
endmodule

// *** cpm_config_port_tb.sv ***
// self-checking bench for the configuration port and mode control
`timescale 1ns/1ns
module cpm_config_port_tb;
  logic clk;
  logic rst = 1'b1;
  logic auxPin0 = 1'b0;
  logic auxPin1 = 1'b0;
  logic clkPresent = 1'b1;
  logic lastWire_ff = 1'b0;
  logic selN, sclk, hostData, hostOe, dataOut, dataOe, dataWire, decimValid, syncRef, pdn;
  logic [15:0] decimFeed;
  logic [7:0] fmt;
  logic [7:0] rdat;
  cpm_pkg::cpm_sample_pair_s sampleIn = 32'h0;
  cpm_pkg::cpm_sample_pair_s sampleOut;
  int nFail = 0;
  int testsRun = 0;
  int cyc_ff = 0;
  // no pull on the data pin: undriven it shows the inverse of its last level
  assign dataWire = dataOe ? dataOut : (hostOe ? hostData : !lastWire_ff);
  always @(posedge clk) lastWire_ff <= dataWire;
  always @(posedge clk) cyc_ff <= cyc_ff + 1;
  always @(negedge clk) sampleIn <= pat(cyc_ff);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  cpm_host_model i_host (.clk(clk), .dataWire(dataWire), .serial_select_n(selN), .serialClk(sclk),
    .hostData(hostData), .hostOe(hostOe));
  cpm_config_port i_dut (.clk(clk), .rst(rst), .serial_select_n(selN), .serialClk(sclk),
    .serialDataIn(dataWire), .serialDataOut(dataOut), .serialDataOe(dataOe), .aux_pin_0(auxPin0),
    .aux_pin_1(auxPin1), .sampleClkPresent(clkPresent), .sampleIn(sampleIn), .sampleOut(sampleOut),
    .decimFeed(decimFeed), .decimFeedValid(decimValid), .sync_reference(syncRef),
    .globalPowerDown(pdn), .outputFormat(fmt));
  // ----
  // helpers
  // ----
  function automatic cpm_pkg::cpm_sample_pair_s pat(input int c);
    pat.chanA = 16'(c * 32'h123 + 32'h8001);
    pat.chanB = 16'(c * 32'h321 + 32'h7ff0);
  endfunction
  // signed sum halved, rounding toward minus infinity
  function automatic logic [15:0] avg(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    return s[16:1];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_host.frame({4'h0, a, d}, 24, 4, rdat);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input int h);
    logic [7:0] r;
    i_host.frame({4'h8, a, 8'h00}, 24, h, r);
    check(r, e);
  endtask
  // lets the pipeline flush, then compares output against input lat cycles back
  task automatic latchk(input int lat, input bit av);
    cpm_pkg::cpm_sample_pair_s p;
    cpm_pkg::cpm_sample_pair_s q;
    repeat (16) @(negedge clk);
    repeat (12) begin
      @(negedge clk);
      p = pat(cyc_ff - lat);
      if (av) begin
        check(sampleOut.chanA, avg(p.chanA, p.chanB));
        q = pat(cyc_ff - 1);
        check(decimFeed, avg(q.chanA, q.chanB));
      end else begin
        check(sampleOut, p);
      end
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_defaults;
    logic [11:0] regs [7] = '{12'h101, 12'h146, 12'h162, 12'h163, 12'h165, 12'h169, 12'h200};
    check(fmt, 8'h00);
    check(pdn, 1'b0);
    auxPin0 = 1'b1;
    repeat (6) @(negedge clk);
    check(syncRef, 1'b1);
    auxPin0 = 1'b0;
    latchk(12, 1'b0);
    foreach (regs[i]) rdchk(regs[i], 8'h00, 4);
  endtask
  task automatic t_port;
    wr(12'h162, 8'ha5);
    check(fmt, 8'ha5);
    rdchk(12'h162, 8'ha5, 4);
    check(fmt, 8'ha5);
    i_host.frame({4'h1, 12'h162, 8'h77}, 24, 4, rdat);
    check(fmt, 8'ha5);
    i_host.frame({4'h0, 12'h162, 8'h3c}, 20, 4, rdat);
    check(fmt, 8'ha5);
    i_host.frame({4'h0, 12'h162, 8'h5a}, 24, 6, rdat);
    rdchk(12'h162, 8'h5a, 6);
    wr(12'h200, 8'hff);
    rdchk(12'h200, 8'h00, 4);
  endtask
  task automatic t_modes;
    cpm_pkg::cpm_sample_pair_s p;
    wr(12'h162, 8'h04);
    wr(12'h163, 8'h02);
    wr(12'h169, 8'h20);
    check(decimValid, 1'b0);
    latchk(12, 1'b1);
    wr(12'h169, 8'h21);
    check(decimValid, 1'b1);
    wr(12'h165, 8'h10);
    check(decimValid, 1'b0);
    latchk(9, 1'b0);
    rdchk(12'h165, 8'h10, 4);
    wr(12'h169, 8'h20);
    wr(12'h165, 8'h00);
    latchk(12, 1'b1);
    wr(12'h163, 8'h01);
    p = pat(cyc_ff - 1);
    check(decimFeed, p.chanB);
  endtask
  task automatic t_power;
    logic [4:0] codes [3] = '{5'h03, 5'h0a, 5'h0b};
    logic on1;
    wr(12'h101, 8'h10);
    check(pdn, 1'b1);
    clkPresent = 1'b0;
    wr(12'h101, 8'h00);
    check(pdn, 1'b1);
    clkPresent = 1'b1;
    repeat (6) @(negedge clk);
    check(pdn, 1'b0);
    foreach (codes[i]) begin
      on1 = codes[i] == 5'h03;
      wr(12'h146, {3'h0, codes[i]});
      {auxPin1, auxPin0} = on1 ? 2'b01 : 2'b10;
      repeat (6) @(negedge clk);
      check(pdn, 1'b0);
      {auxPin1, auxPin0} = on1 ? 2'b10 : 2'b01;
      repeat (6) @(negedge clk);
      check(pdn, 1'b1);
      {auxPin1, auxPin0} = 2'b00;
      repeat (6) @(negedge clk);
      check(pdn, 1'b0);
    end
  endtask
  task automatic conclude;
    if (nFail == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_defaults();
    t_port();
    t_modes();
    t_power();
    conclude();
  end
  // about four times the expected run
  initial begin
    repeat (25000) @(posedge clk);
    nFail++;
    conclude();
  end
endmodule
